// File: hw/ccr_div.sv
// ccr_div: glitch-free divider producing a one-cycle enable every ratio cycles
`default_nettype none
module ccr_div #(
    parameter int W = 4
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         run,
    input  wire logic [W-1:0] ratio,
    output logic              tick
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic [W-1:0] per_r;
    logic [W-1:0] per_nxt;
    logic         tick_r;
    logic         tick_nxt;

    if (W < 4) begin : g_chk
        $error("ccr_div: W must be at least 4");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // new ratio is taken only at a period boundary or while run is low, so no runt period
    always_comb begin
        cnt_nxt  = cnt_r;
        per_nxt  = per_r;
        tick_nxt = 1'b0;
        if (!run) begin
            cnt_nxt = '0;
            per_nxt = ratio;
        end else if (cnt_r >= per_r - W'(1)) begin
            cnt_nxt  = '0;
            per_nxt  = ratio;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r  <= '0;
            per_r  <= W'(1);
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            per_r  <= per_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_div_one;
        (run && per_r == W'(1)) |=> tick;
    endproperty
    a_div_one: assert property (p_div_one) else $error("divide by one lost a tick");
endmodule : ccr_div
`default_nettype wire

// File: hw/ccr_pkg.sv
// ccr_pkg: types of the clock/regulator control block
`default_nettype none
package ccr_pkg;
    typedef enum logic [2:0] {
        CCR_ST_BOOT = 3'h1,
        CCR_ST_RUN  = 3'h2,
        CCR_ST_HIB  = 3'h4
    } ccr_state_e;

    typedef struct packed {
        logic [1:0] csel;
        logic [3:0] ssel;
    } ccr_div_s;

    typedef struct packed {
        logic       byp;
        logic [3:0] lvl;
    } ccr_vr_s;

    typedef struct packed {
        logic core_tick;
        logic sys_tick;
    } ccr_clk_s;
endpackage : ccr_pkg
`default_nettype wire

// File: hw/ccr_regs.svh
// ccr_regs.svh: offsets, field positions, reset values of the clock/regulator control block
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH

// register byte offsets
`define CCR_OFS_DIV      8'h00
`define CCR_OFS_VR       8'h04
`define CCR_OFS_PLL      8'h08
`define CCR_OFS_KEY      8'h0C
`define CCR_OFS_STAT     8'h10

// field positions
`define CCR_DIV_SSEL_LSB 0
`define CCR_DIV_CSEL_LSB 4
`define CCR_VR_LVL_LSB   0
`define CCR_VR_HIB_BIT   4
`define CCR_VR_BYP_BIT   5
`define CCR_PLL_MUL_LSB  0
`define CCR_STAT_HIB_BIT 0
`define CCR_STAT_RTC_BIT 1
`define CCR_STAT_UNL_BIT 2

// reset values and limits
`define CCR_RST_SSEL     4'h5
`define CCR_RST_CSEL     2'h0
`define CCR_RST_LVL      4'h8
`define CCR_RST_MULT     8'h14
`define CCR_MULT_MIN     8'h01
`define CCR_MULT_MAX     8'h80
`define CCR_VR_STEP_MV   50
`define CCR_PLL_KEY      32'h0000_C10C

// bus answers
`define CCR_RESP_OKAY    2'h0
`define CCR_RESP_SLVERR  2'h2

`endif

// File: hw/ccr_top.sv
// ccr_top: core/system clock dividers, pll multiplier and regulator control, axi4-lite slave
// Summary of operation
// - core voltage level programmable in 50 mV steps
// - hibernate removes core power, io supply stays
// - rtc wakeup or reset leaves hibernate, boots
// - regulator can be disabled and bypassed externally
// - clocks derive from input; pll 0.5x to 64x
// - pll factor resets to 10x, keyed change only
// - divider writes take effect without pll relock
// - all peripherals share one system clock enable
// - system divide equals select value, 1 to 15
// - core divide 1, 2, 4, 8 from select
`default_nettype none
`include "ccr_regs.svh"
module ccr_top
    import ccr_pkg::*;
#(
    parameter logic [7:0] MULT_MIN = `CCR_MULT_MIN,
    parameter logic [7:0] MULT_MAX = `CCR_MULT_MAX
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        rtc_wake,
    output ccr_clk_s         clk_en,
    output logic [7:0]       pll_mult,
    output logic [3:0]       vr_level,
    output logic             regulator_bypass,
    output logic             core_power_en,
    output logic             boot_start
);
    if (MULT_MIN < 8'h01 || MULT_MAX < MULT_MIN) begin : g_chk
        $error("ccr_top: bad multiplier bounds");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel
    logic        aw_have_r;
    logic        aw_have_nxt;
    logic        w_have_r;
    logic        w_have_nxt;
    logic [7:0]  waddr_r;
    logic [7:0]  waddr_nxt;
    logic [31:0] wdat_r;
    logic [31:0] wdat_nxt;
    logic [3:0]  wstb_r;
    logic [3:0]  wstb_nxt;
    logic        bvalid_r;
    logic        bvalid_nxt;
    logic [1:0]  bresp_r;
    logic [1:0]  bresp_nxt;
    logic        wr_fire;
    logic        wr_hit;

    // address and data land in holding registers; either order works
    assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
    assign wr_hit  = (waddr_r == `CCR_OFS_DIV) || (waddr_r == `CCR_OFS_VR)
                  || (waddr_r == `CCR_OFS_PLL) || (waddr_r == `CCR_OFS_KEY)
                  || (waddr_r == `CCR_OFS_STAT);

    always_comb begin
        aw_have_nxt = aw_have_r;
        w_have_nxt  = w_have_r;
        waddr_nxt   = waddr_r;
        wdat_nxt    = wdat_r;
        wstb_nxt    = wstb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        if (awvalid && awready) begin
            aw_have_nxt = 1'b1;
            waddr_nxt   = awaddr;
        end
        if (wvalid && wready) begin
            w_have_nxt = 1'b1;
            wdat_nxt   = wdata;
            wstb_nxt   = wstrb;
        end
        if (wr_fire) begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_hit ? `CCR_RESP_OKAY : `CCR_RESP_SLVERR;
        end else if (bvalid_r && bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            waddr_r   <= 8'h00;
            wdat_r    <= 32'h0000_0000;
            wstb_r    <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `CCR_RESP_OKAY;
        end else begin
            aw_have_r <= aw_have_nxt;
            w_have_r  <= w_have_nxt;
            waddr_r   <= waddr_nxt;
            wdat_r    <= wdat_nxt;
            wstb_r    <= wstb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
        end
    end

    assign awready = !aw_have_r;
    assign wready  = !w_have_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;

    ////////////////////////////////////////////////////////////////////////////////
    // control registers
    ccr_div_s   div_r;
    ccr_div_s   div_nxt;
    ccr_vr_s    vr_r;
    ccr_vr_s    vr_nxt;
    logic [7:0] mult_r;
    logic [7:0] mult_nxt;
    logic       unlock_r;
    logic       unlock_nxt;
    logic       hib_req;
    logic [3:0] ssel_w;
    logic [7:0] mult_w;

    assign ssel_w = wdat_r[`CCR_DIV_SSEL_LSB +: 4];
    assign mult_w = wdat_r[`CCR_PLL_MUL_LSB +: 8];

    always_comb begin
        div_nxt    = div_r;
        vr_nxt     = vr_r;
        mult_nxt   = mult_r;
        unlock_nxt = unlock_r;
        hib_req    = 1'b0;
        if (wr_fire) begin
            // any write other than the key relocks the multiplier
            unlock_nxt = 1'b0;
            case (waddr_r)
                `CCR_OFS_DIV: begin
                    if (wstb_r[0]) begin
                        div_nxt.csel = wdat_r[`CCR_DIV_CSEL_LSB +: 2];
                        if (ssel_w != 4'h0) begin
                            div_nxt.ssel = ssel_w;
                        end
                    end
                end
                `CCR_OFS_VR: begin
                    if (wstb_r[0]) begin
                        vr_nxt.lvl = wdat_r[`CCR_VR_LVL_LSB +: 4];
                        vr_nxt.byp = wdat_r[`CCR_VR_BYP_BIT];
                        // a bypassed regulator has no core supply to cut
                        hib_req    = wdat_r[`CCR_VR_HIB_BIT] && !wdat_r[`CCR_VR_BYP_BIT];
                    end
                end
                `CCR_OFS_KEY: begin
                    unlock_nxt = (wstb_r == 4'hF) && (wdat_r == `CCR_PLL_KEY);
                end
                `CCR_OFS_PLL: begin
                    if (unlock_r && wstb_r[0] && mult_w >= MULT_MIN && mult_w <= MULT_MAX) begin
                        mult_nxt = mult_w;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r    <= '{csel: `CCR_RST_CSEL, ssel: `CCR_RST_SSEL};
            vr_r     <= '{byp: 1'b0, lvl: `CCR_RST_LVL};
            mult_r   <= `CCR_RST_MULT;
            unlock_r <= 1'b0;
        end else begin
            div_r    <= div_nxt;
            vr_r     <= vr_nxt;
            mult_r   <= mult_nxt;
            unlock_r <= unlock_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power state: boot, run, hibernate
    ccr_state_e state_r;
    ccr_state_e state_nxt;
    logic       cause_rtc_r;
    logic       cause_rtc_nxt;
    logic       rtc_s1_r;
    logic       rtc_s2_r;

    always_comb begin
        state_nxt     = state_r;
        cause_rtc_nxt = cause_rtc_r;
        case (state_r)
            CCR_ST_BOOT: state_nxt = CCR_ST_RUN;
            CCR_ST_RUN: begin
                if (hib_req) begin
                    state_nxt = CCR_ST_HIB;
                end
            end
            CCR_ST_HIB: begin
                if (rtc_s2_r) begin
                    state_nxt     = CCR_ST_BOOT;
                    cause_rtc_nxt = 1'b1;
                end
            end
            default: state_nxt = CCR_ST_BOOT;
        endcase
    end

    // reset is the other wake path: it lands in boot with cause cleared
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r     <= CCR_ST_BOOT;
            cause_rtc_r <= 1'b0;
            rtc_s1_r    <= 1'b0;
            rtc_s2_r    <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            cause_rtc_r <= cause_rtc_nxt;
            rtc_s1_r    <= rtc_wake;
            rtc_s2_r    <= rtc_s1_r;
        end
    end

    assign boot_start       = (state_r == CCR_ST_BOOT);
    assign core_power_en    = (state_r != CCR_ST_HIB);
    assign vr_level         = vr_r.lvl;
    assign regulator_bypass = vr_r.byp;
    assign pll_mult         = mult_r;

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0]  rresp_r;
    logic [1:0]  rresp_nxt;

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (arvalid && arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `CCR_RESP_OKAY;
            case (araddr)
                `CCR_OFS_DIV:  rdata_nxt = {26'h000_0000, div_r};
                `CCR_OFS_VR:   rdata_nxt = {26'h000_0000, vr_r.byp, 1'b0, vr_r.lvl};
                `CCR_OFS_PLL:  rdata_nxt = {24'h00_0000, mult_r};
                `CCR_OFS_KEY:  rdata_nxt = 32'h0000_0000;
                `CCR_OFS_STAT: rdata_nxt = {29'h0000_0000, unlock_r, cause_rtc_r,
                                            state_r == CCR_ST_HIB};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = `CCR_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= `CCR_RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r  <= rdata_nxt;
            rresp_r  <= rresp_nxt;
        end
    end

    assign arready = !rvalid_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;

    ////////////////////////////////////////////////////////////////////////////////
    // derived clocks: aclk stands for the vco; both stop in hibernate
    logic [3:0] core_ratio;
    logic       core_tick;
    logic       sys_tick;

    assign core_ratio = 4'(4'h1 << div_r.csel);

    ccr_div #(.W(4)) u_core_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (core_power_en),
        .ratio   (core_ratio),
        .tick    (core_tick)
    );

    ccr_div #(.W(4)) u_sys_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (core_power_en),
        .ratio   (div_r.ssel),
        .tick    (sys_tick)
    );

    // one shared enable for every peripheral
    assign clk_en = '{core_tick: core_tick, sys_tick: sys_tick};

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_ssel_zero;
        (wr_fire && waddr_r == `CCR_OFS_DIV && wstb_r[0] && ssel_w == 4'h0)
            |=> $stable(div_r.ssel);
    endproperty
    a_ssel_zero: assert property (p_ssel_zero) else $error("zero ssel applied");

    property p_ssel_set;
        (wr_fire && waddr_r == `CCR_OFS_DIV && wstb_r[0] && ssel_w != 4'h0)
            |=> div_r.ssel == $past(ssel_w);
    endproperty
    a_ssel_set: assert property (p_ssel_set) else $error("ssel not applied");

    property p_csel;
        (wr_fire && waddr_r == `CCR_OFS_DIV && wstb_r[0])
            |=> core_ratio == 4'(4'h1 << $past(wdat_r[5:4]));
    endproperty
    a_csel: assert property (p_csel) else $error("core ratio wrong");

    property p_lvl;
        (wr_fire && waddr_r == `CCR_OFS_VR && wstb_r[0]) |=> vr_level == $past(wdat_r[3:0]);
    endproperty
    a_lvl: assert property (p_lvl) else $error("regulator level not set");

    property p_hib_enter;
        (state_r == CCR_ST_RUN && wr_fire && waddr_r == `CCR_OFS_VR && wstb_r[0]
            && wdat_r[4] && !wdat_r[5]) |=> !core_power_en;
    endproperty
    a_hib_enter: assert property (p_hib_enter) else $error("hibernate not entered");

    property p_byp_hold;
        (state_r == CCR_ST_RUN && wr_fire && wdat_r[5]) |=> core_power_en;
    endproperty
    a_byp_hold: assert property (p_byp_hold) else $error("bypassed core lost power");

    property p_wake;
        (state_r == CCR_ST_HIB && rtc_s2_r) |=> boot_start ##1 (core_power_en && !boot_start);
    endproperty
    a_wake: assert property (p_wake) else $error("rtc wake did not boot");

    property p_mult_lock;
        !unlock_r |=> $stable(mult_r);
    endproperty
    a_mult_lock: assert property (p_mult_lock) else $error("pll changed while locked");

    property p_mult_range;
        mult_r >= MULT_MIN && mult_r <= MULT_MAX;
    endproperty
    a_mult_range: assert property (p_mult_range) else $error("pll factor out of range");

    property p_hib_clocks;
        !core_power_en ##1 !core_power_en |-> !clk_en.sys_tick && !clk_en.core_tick;
    endproperty
    a_hib_clocks: assert property (p_hib_clocks) else $error("clock ran in hibernate");
endmodule : ccr_top
`default_nettype wire

// File: verification/ccr_osc_model.sv
// ccr_osc_model: free-running input clock source for the clock/regulator bench
`default_nettype none
module ccr_osc_model #(
    parameter int HALF_NS = 50
) (
    output logic clk
);
    timeunit 1ns;
    timeprecision 100ps;
    // never halted or retuned: divider periods stay exact cycle counts
    initial begin
        clk = 1'b0;
        forever #(HALF_NS) clk = ~clk;
    end
endmodule : ccr_osc_model
`default_nettype wire

// File: verification/ccr_top_tb_top.sv
// ccr_top_tb_top: register-driven bench for the clock/regulator control block
`default_nettype none
`include "ccr_regs.svh"
module ccr_top_tb_top
    import ccr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, rtc_wake, regulator_bypass;
    logic        core_power_en, boot_start;
    logic [7:0]  awaddr, araddr, pll_mult, per;
    logic [31:0] wdata, rdata, rd_d;
    logic [3:0]  wstrb, vr_level;
    logic [1:0]  bresp, rresp, resp;
    ccr_clk_s    clk_en;
    int          n_mismatch, samples_checked, cnt;
    logic [3:0]  ssel_tab [3] = '{4'h1, 4'ha, 4'hf};

    ccr_osc_model #(.HALF_NS(50)) i_ccr_osc_model (.clk(aclk));

    ccr_top i_ccr_top (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .rtc_wake(rtc_wake),
        .clk_en(clk_en), .pll_mult(pll_mult), .vr_level(vr_level),
        .regulator_bypass(regulator_bypass), .core_power_en(core_power_en),
        .boot_start(boot_start)
    );

    ////////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task tally_and_finish;
        $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task timed_out(input string what);
        n_mismatch++;
        $display("unexpected timeout on %s", what);
        tally_and_finish();
    endtask : timed_out

    ////////////////////////////////////////////////////////////////////////////
    task wr(input logic [7:0] a, input logic [31:0] d);
        int   g;
        logic aw_ok, w_ok;
        g = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        // each channel released on its own handshake edge
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            g++;
            if (awready === 1'b1 && !aw_ok) awvalid <= 1'b0;
            if (awready === 1'b1) aw_ok = 1'b1;
            if (wready === 1'b1 && !w_ok) wvalid <= 1'b0;
            if (wready === 1'b1) w_ok = 1'b1;
            if (g > 50) timed_out("write handshake");
        end
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            g++;
        end while (bvalid !== 1'b1 && g < 100);
        resp = bresp;
        bready <= 1'b0;
        if (g >= 100) timed_out("write response");
        @(negedge aclk);
    endtask : wr

    task rd(input logic [7:0] a);
        int g;
        g = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            g++;
        end while (arready !== 1'b1 && g < 50);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            g++;
        end while (rvalid !== 1'b1 && g < 100);
        rd_d = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (g >= 100) timed_out("read response");
        @(negedge aclk);
    endtask : rd

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        rd(a);
        check(rd_d, exp, what);
    endtask : rd_chk

    // cycles between two successive enables; first one only synchronises
    task measure(input bit core, output logic [7:0] p);
        int g;
        g = 0;
        do begin
            @(posedge aclk);
            g++;
        end while (!(core ? clk_en.core_tick : clk_en.sys_tick) && g < 40);
        p = 8'h00;
        do begin
            @(posedge aclk);
            p++;
        end while (!(core ? clk_en.core_tick : clk_en.sys_tick) && p < 8'h28);
        if (g >= 40) timed_out("divider enable");
    endtask : measure

    task do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, rtc_wake} <= '0;
        {awaddr, araddr, wstrb, wdata} <= '0;
        n_mismatch = 0;
        samples_checked = 0;
        do_reset();
        check(pll_mult, 8'h14, "reset multiplier");
        check(vr_level, 4'h8, "reset level");
        check(regulator_bypass, 1'b0, "reset bypass");
        check(core_power_en, 1'b1, "reset core power");
        check(boot_start, 1'b1, "reset boot start");
        rd_chk(`CCR_OFS_DIV, 32'h0000_0005, "reset divider");
        check(resp, `CCR_RESP_OKAY, "divider read response");
        measure(1'b0, per);
        check(per, 8'h05, "default system period");
        // walk system select values; new ratio lands within one old period
        foreach (ssel_tab[i]) begin
            wr(`CCR_OFS_DIV, {28'h0, ssel_tab[i]});
            measure(1'b0, per);
            measure(1'b0, per);
            check(per, {4'h0, ssel_tab[i]}, "system period");
        end
        wr(`CCR_OFS_DIV, 32'h0000_0000);
        check(resp, `CCR_RESP_OKAY, "zero select write response");
        rd_chk(`CCR_OFS_DIV, 32'h0000_000f, "zero select kept old");
        for (int c = 0; c < 4; c++) begin
            wr(`CCR_OFS_DIV, 32'h0000_0003 | (c << 4));
            measure(1'b1, per);
            measure(1'b1, per);
            check(per, 8'h01 << c, "core period");
            measure(1'b0, per);
            check(per, 8'h03, "system period beside core");
        end
        // multiplier only moves right after the key
        wr(`CCR_OFS_PLL, 32'h0000_0001);
        check(pll_mult, 8'h14, "unkeyed multiplier");
        wr(`CCR_OFS_KEY, `CCR_PLL_KEY);
        rd_chk(`CCR_OFS_STAT, 32'h0000_0004, "unlock status");
        wr(`CCR_OFS_PLL, 32'h0000_0001);
        check(pll_mult, 8'h01, "half multiplier");
        wr(`CCR_OFS_KEY, `CCR_PLL_KEY);
        wr(`CCR_OFS_PLL, 32'h0000_0080);
        check(pll_mult, 8'h80, "top multiplier");
        wr(`CCR_OFS_KEY, `CCR_PLL_KEY);
        wr(`CCR_OFS_PLL, 32'h0000_0000);
        check(pll_mult, 8'h80, "zero multiplier refused");
        wr(`CCR_OFS_KEY, `CCR_PLL_KEY);
        wr(`CCR_OFS_VR, 32'h0000_0003);
        wr(`CCR_OFS_PLL, 32'h0000_0020);
        check(pll_mult, 8'h80, "broken key sequence");
        wr(`CCR_OFS_KEY, 32'h0000_1234);
        wr(`CCR_OFS_PLL, 32'h0000_0020);
        check(pll_mult, 8'h80, "wrong key value");
        check(vr_level, 4'h3, "level code");
        wr(`CCR_OFS_VR, 32'h0000_0023);
        check(regulator_bypass, 1'b1, "bypass on");
        wr(`CCR_OFS_VR, 32'h0000_0033);
        check(core_power_en, 1'b1, "hibernate refused in bypass");
        // hibernate, then wake from the rtc pin
        wr(`CCR_OFS_VR, 32'h0000_0013);
        check(core_power_en, 1'b0, "hibernate power");
        cnt = 0;
        repeat (20) begin
            @(posedge aclk);
            if (clk_en !== 2'b00) cnt++;
        end
        check(cnt, 0, "enables in hibernate");
        rd_chk(`CCR_OFS_STAT, 32'h0000_0001, "hibernate status");
        @(posedge aclk);
        rtc_wake <= 1'b1;
        cnt = 0;
        do begin
            @(negedge aclk);
            cnt++;
        end while (boot_start !== 1'b1 && cnt < 20);
        check(cnt < 20, 1'b1, "rtc boot start");
        @(posedge aclk);
        rtc_wake <= 1'b0;
        @(negedge aclk);
        check(boot_start, 1'b0, "boot pulse width");
        check(core_power_en, 1'b1, "rtc wake power");
        rd_chk(`CCR_OFS_STAT, 32'h0000_0002, "rtc wake cause");
        // hibernate again, leave by reset
        wr(`CCR_OFS_VR, 32'h0000_0013);
        do_reset();
        check(core_power_en, 1'b1, "reset wake power");
        check(pll_mult, 8'h14, "multiplier after reset");
        rd_chk(`CCR_OFS_STAT, 32'h0000_0000, "reset wake cause");
        rd(8'h40);
        check(rd_d, 32'h0000_0000, "unmapped read data");
        check(resp, `CCR_RESP_SLVERR, "unmapped read response");
        wr(8'h40, 32'h0000_0001);
        check(resp, `CCR_RESP_SLVERR, "unmapped write");
        tally_and_finish();
    end
endmodule : ccr_top_tb_top
`default_nettype wire
